//--- odl_pkg.sv
package odl_pkg;
  // ==========================================================
  // Word layout
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CHANNELS = 8;
  localparam int CODE_MSB_POS = 15;
  localparam int CODE_LSB_POS = 4;
  localparam int ADDR_POS = 3;
  localparam int SEL_MSB_POS = 2;
  localparam int SEL_LSB_POS = 0;
  // ==========================================================
  // Counts and reset values
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam logic [4:0] BIT_COUNT_RST = 5'h00;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [1:0] SYNC_RST = 2'h3;
  localparam logic [1:0] SYNC_CLK_RST = 2'h0;
  localparam logic [1:0] SLOTS = 2'h2;
endpackage

//--- odl_loader.sv
`timescale 1ns/1ps
// Operation
// - Sample serial input on falling shift clock
// - Frame sync active low enables shifting
// - Frame sync low arms the shift register
// - Sixteenth edge writes code to input latch
// - Word sent MSB first, code MSB first
// - Address bit mismatch with strap discards word
// - Opposite straps let two devices share bus
// - Select bits pick channel A through H
// - Chain output forwards every word regardless
// - Chain register, loaded from shift register on the first rising edge after word end, drives chain output
// - Load low copies all input latches out
// - Clear low zeroes all output latches
// - After sixteen bits ignore edges until resync
// - Chain output updates on following rising edge
// - Clear leaves input latches untouched
module odl_loader
  import odl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial link
  input wire logic frame_sync_n,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic chain_out,
  // Strap and update controls
  input wire logic address_strap,
  input wire logic load_all_n,
  input wire logic clear_outputs_n,
  // Converter codes, channel n at bits [12n+11:12n]
  output logic [CHANNELS*CODE_BITS-1:0] dac_codes,
  output logic word_accepted,
  output logic word_dropped
);

  // ==========================================================
  // Input synchronisers
  logic [1:0] fs_sync_r;
  logic [1:0] sck_sync_r;
  logic [1:0] sdi_sync_r;
  logic [1:0] strap_sync_r;
  logic [1:0] ld_sync_r;
  logic [1:0] clr_sync_r;
  logic sck_prev_r;
  logic fs_prev_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fs_sync_r <= SYNC_RST;
      sck_sync_r <= SYNC_CLK_RST;
      sdi_sync_r <= SYNC_CLK_RST;
      strap_sync_r <= SYNC_CLK_RST;
      ld_sync_r <= SYNC_RST;
      clr_sync_r <= SYNC_RST;
      sck_prev_r <= 1'b0;
      fs_prev_r <= 1'b1;
    end else begin
      fs_sync_r <= {fs_sync_r[0], frame_sync_n};
      sck_sync_r <= {sck_sync_r[0], shift_clock};
      sdi_sync_r <= {sdi_sync_r[0], serial_in};
      strap_sync_r <= {strap_sync_r[0], address_strap};
      ld_sync_r <= {ld_sync_r[0], load_all_n};
      clr_sync_r <= {clr_sync_r[0], clear_outputs_n};
      sck_prev_r <= sck_sync_r[1];
      fs_prev_r <= fs_sync_r[1];
    end
  end

  logic fs_n;
  logic sck_fall;
  logic sck_rise;
  logic fs_fall;
  assign fs_n = fs_sync_r[1];
  assign sck_fall = sck_prev_r & ~sck_sync_r[1];
  assign sck_rise = ~sck_prev_r & sck_sync_r[1];
  assign fs_fall = fs_prev_r & ~fs_n;

  // ==========================================================
  // Shift register and bit counter
  logic [WORD_BITS-1:0] shift_r;
  logic [4:0] count_r;
  logic armed;
  logic word_done;

  // Frame progress: idle, taking bits, or full and deaf to the clock
  typedef enum logic [1:0] {
    FRM_IDLE = 2'h0,
    FRM_SHIFT = 2'h1,
    FRM_FULL = 2'h2
  } odl_frame_t;
  odl_frame_t frame_r;

  assign armed = (frame_r == FRM_SHIFT);

  // Word completes on the sixteenth falling edge of an armed frame
  assign word_done = sck_fall & ~fs_n & armed &
                     (count_r == BIT_COUNT_FULL - 5'h01);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_r <= FRM_IDLE;
    end else if (fs_fall) begin
      frame_r <= FRM_SHIFT;
    end else begin
      case (frame_r)
        FRM_IDLE: begin
          // A frame already low at reset release still arms, as the frame sync synchroniser stages reset high
          frame_r <= FRM_IDLE;
        end
        FRM_SHIFT: begin
          if (fs_n) begin
            // Early rise of frame sync abandons the partial word
            frame_r <= FRM_IDLE;
          end else if (word_done) begin
            frame_r <= FRM_FULL;
          end
        end
        FRM_FULL: begin
          // Extra clock edges are ignored until frame sync cycles
          if (fs_n) begin
            frame_r <= FRM_IDLE;
          end
        end
        default: begin
          frame_r <= FRM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_r <= BIT_COUNT_RST;
    end else if (fs_fall) begin
      count_r <= BIT_COUNT_RST;
    end else if (word_done) begin
      count_r <= BIT_COUNT_FULL;
    end else if (sck_fall && armed && !fs_n) begin
      count_r <= count_r + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_r <= SHIFT_RST;
    end else if (sck_fall && armed && !fs_n) begin
      shift_r <= {shift_r[WORD_BITS-2:0], sdi_sync_r[1]};
    end
  end

  // ==========================================================
  // Two-entry word buffer between shifter and latch writer
  // Holding whole words means a burst of back-to-back frames is
  // not lost while the writer is busy.
  logic [WORD_BITS-1:0] buf_mem_r [0:1];
  logic buf_wp_r;
  logic buf_rp_r;
  logic [1:0] buf_cnt_r;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [WORD_BITS-1:0] done_word;
  logic wr_valid_r;

  assign done_word = {shift_r[WORD_BITS-2:0], sdi_sync_r[1]};
  assign buf_in_valid = word_done;
  assign buf_in_ready = (buf_cnt_r != SLOTS);
  assign buf_out_valid = (buf_cnt_r != 2'h0);
  // Writer takes one word per two cycles; a word finding both slots
  // full would be lost, but frames are far longer than the drain
  assign buf_out_ready = ~wr_valid_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_cnt_r <= 2'h0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_mem_r[buf_wp_r] <= done_word;
        buf_wp_r <= ~buf_wp_r;
      end
      if (buf_out_valid && buf_out_ready) begin
        buf_rp_r <= ~buf_rp_r;
      end
      buf_cnt_r <= buf_cnt_r
                   + {1'b0, buf_in_valid & buf_in_ready}
                   - {1'b0, buf_out_valid & buf_out_ready};
    end
  end

  logic [WORD_BITS-1:0] head_word;
  assign head_word = buf_mem_r[buf_rp_r];

  // ==========================================================
  // Latch writer stage
  // The writer holds one word for a cycle; while busy it refuses the
  // buffer, and the second slot keeps a word that arrives meanwhile
  logic [WORD_BITS-1:0] wr_word_r;
  logic addr_match;
  logic [2:0] wr_sel;
  logic [CHANNELS-1:0] wr_hot;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_valid_r <= 1'b0;
    end else begin
      wr_valid_r <= buf_out_valid & buf_out_ready;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_word_r <= SHIFT_RST;
    end else if (buf_out_valid && buf_out_ready) begin
      wr_word_r <= head_word;
    end
  end

  assign addr_match = (wr_word_r[ADDR_POS] == strap_sync_r[1]);
  assign wr_sel = wr_word_r[SEL_MSB_POS:SEL_LSB_POS];

  // One-hot channel pick from the three select bits
  function automatic logic [CHANNELS-1:0] chan_pick(input logic [2:0] sel);
    logic [CHANNELS-1:0] hot;
    hot = '0;
    hot[sel] = 1'b1;
    return hot;
  endfunction
  assign wr_hot = chan_pick(wr_sel);

  // ==========================================================
  // Chain output: full word shifted out, MSB first, on rising edges
  logic [WORD_BITS-1:0] chain_r;
  logic chain_load_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chain_load_r <= 1'b0;
    end else if (word_done) begin
      chain_load_r <= 1'b1;
    end else if (sck_rise) begin
      chain_load_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chain_r <= SHIFT_RST;
      chain_out <= 1'b0;
    end else if (sck_rise && chain_load_r) begin
      // Every word goes downstream whatever its address bit
      chain_r <= {shift_r[WORD_BITS-2:0], 1'b0};
      chain_out <= shift_r[WORD_BITS-1];
    end else if (sck_rise) begin
      chain_r <= {chain_r[WORD_BITS-2:0], 1'b0};
      chain_out <= chain_r[WORD_BITS-1];
    end
  end

  // ==========================================================
  // Input and output latches
  logic [CODE_BITS-1:0] in_latch_r [0:CHANNELS-1];
  logic ld_active;
  logic clr_active;
  assign ld_active = ~ld_sync_r[1];
  assign clr_active = ~clr_sync_r[1];

  // Each word is reported once, in the cycle its latch is written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_accepted <= 1'b0;
      word_dropped <= 1'b0;
    end else begin
      word_accepted <= wr_valid_r & addr_match;
      word_dropped <= wr_valid_r & ~addr_match;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          in_latch_r[ch] <= CODE_RST;
        end else if (wr_valid_r && addr_match && wr_hot[ch]) begin
          // Clear never touches this latch
          in_latch_r[ch] <=
            wr_word_r[CODE_MSB_POS:CODE_LSB_POS];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          dac_codes[ch*CODE_BITS +: CODE_BITS] <= CODE_RST;
        end else if (clr_active) begin
          dac_codes[ch*CODE_BITS +: CODE_BITS] <= CODE_RST;
        end else if (ld_active) begin
          // Transparent while load is low, all channels at once
          dac_codes[ch*CODE_BITS +: CODE_BITS] <=
            in_latch_r[ch];
        end
      end
    end
  endgenerate

endmodule

//--- odl_loader_props.sv
`timescale 1ns/1ps
// ==========
// Port checks for the serial loader
module odl_loader_props
  import odl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_sync_n,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic chain_out,
  input wire logic address_strap,
  input wire logic load_all_n,
  input wire logic clear_outputs_n,
  input wire logic [CHANNELS*CODE_BITS-1:0] dac_codes,
  input wire logic word_accepted,
  input wire logic word_dropped
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic pulse = word_accepted | word_dropped;
  a_pulse_excl: assert property (!(word_accepted && word_dropped))
    else $error("accept and drop together");
  a_accept_gap: assert property (word_accepted |=> !pulse [*8])
    else $error("second verdict too soon after accept");
  a_drop_gap: assert property (word_dropped |=> !pulse)
    else $error("drop pulse longer than one cycle");
  a_clear_zero: assert property ((!clear_outputs_n) [*4] |-> dac_codes == '0)
    else $error("codes not zero under clear");
  a_clear_hold: assert property ((!clear_outputs_n) [*4] ##1
    (clear_outputs_n && load_all_n) [*4] |-> dac_codes == '0)
    else $error("codes returned without load");
  a_codes_hold: assert property ((load_all_n && clear_outputs_n) [*5]
    |-> $stable(dac_codes))
    else $error("codes moved without load or clear");
  a_chain_hold: assert property ((!shift_clock) [*8] |=> $stable(chain_out))
    else $error("chain output moved with clock low");
  a_idle_quiet: assert property (frame_sync_n [*8] |-> !pulse)
    else $error("verdict outside a frame");
endmodule
bind odl_loader odl_loader_props u_props (.ref_clk(ref_clk), .rst(rst),
  .frame_sync_n(frame_sync_n), .shift_clock(shift_clock),
  .serial_in(serial_in), .chain_out(chain_out), .address_strap(address_strap),
  .load_all_n(load_all_n), .clear_outputs_n(clear_outputs_n),
  .dac_codes(dac_codes), .word_accepted(word_accepted),
  .word_dropped(word_dropped));

//--- odl_host.sv
`timescale 1ns/1ps
// ==========
// Frame source; clock rests low between frames like a pulled-down line
module odl_host (
  input wire logic ref_clk,
  output logic frame_sync_n,
  output logic shift_clock,
  output logic serial_in,
  input wire logic chain_out,
  output logic [15:0] rx_word
);
  initial begin
    frame_sync_n = 1;
    shift_clock = 0;
    serial_in = 0;
    rx_word = '0;
  end
  task automatic hw(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Counts below 16 leave partial words abandoned with no verdict; counts above 16 check that extra edges are ignored
  task automatic send(logic [15:0] w, int n);
    hw(1);
    frame_sync_n = 0;
    for (int i = 0; i < n; i++) begin
      hw(10);
      shift_clock = 1;
      serial_in = w[15 - (i % 16)];
      hw(10);
      rx_word = {rx_word[14:0], chain_out};
      shift_clock = 0;
    end
    hw(10);
    frame_sync_n = 1;
    serial_in = ~serial_in;
    // Frame sync rests high long enough to separate frames clearly
    hw(12);
  endtask
endmodule

//--- odl_loader_tb.sv
`timescale 1ns/1ps
module odl_loader_tb;
  import odl_pkg::*;
  logic ref_clk, rst, fs_n, sck, sdi, chain, strap, load_n, clr_n, acc, drop;
  logic [CHANNELS*CODE_BITS-1:0] codes, mdl;
  logic [15:0] rx;
  logic q[$];
  logic exp_acc;
  int err_count, checked;
  odl_loader dut (.ref_clk(ref_clk), .rst(rst), .frame_sync_n(fs_n),
    .shift_clock(sck), .serial_in(sdi), .chain_out(chain),
    .address_strap(strap), .load_all_n(load_n), .clear_outputs_n(clr_n),
    .dac_codes(codes), .word_accepted(acc), .word_dropped(drop));
  odl_host host (.ref_clk(ref_clk), .frame_sync_n(fs_n), .shift_clock(sck),
    .serial_in(sdi), .chain_out(chain), .rx_word(rx));
  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(string n, logic [95:0] e, logic [95:0] g);
    checked++;
    if (e !== g) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // Verdict monitor: each pulse takes the oldest note
  always @(posedge ref_clk) if (acc === 1'b1 || drop === 1'b1) begin
    if (q.size() == 0) chk("stray pulse", 0, 1);
    else begin
      exp_acc = q.pop_front();
      chk("accepted", exp_acc, acc);
      chk("dropped", !exp_acc, drop);
    end
  end
  task automatic word(logic [11:0] c, logic a, logic [2:0] ch, int n);
    if (n >= 16) q.push_back(a == strap);
    if (n >= 16 && a == strap) mdl[12*ch +: 12] = c;
    host.send({c, a, ch}, n);
    chk("pending", 0, q.size());
  endtask
  task automatic pins(logic l, logic c);
    @(posedge ref_clk);
    #1;
    load_n = l;
    clr_n = c;
    repeat (6) @(posedge ref_clk);
  endtask
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h72C80666));
    {rst, strap, load_n, clr_n, mdl, err_count, checked} = '0;
    {rst, load_n, clr_n} = 3'h7;
    repeat (10) @(posedge ref_clk);
    #1 rst = 0;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) word(12'($urandom), 1'b0, 3'(i), 16);
    chk("chain", {mdl[83:72], 4'h6}, rx);
    word(12'hFFF, 1'b1, 3'h0, 16);
    word(12'h5A5, 1'b0, 3'h1, 16);
    chk("chain", 16'hFFF8, rx);
    word(12'h3C3, 1'b0, 3'h2, 10);
    word(12'h0F0, 1'b0, 3'h3, 20);
    pins(0, 1);
    chk("load", mdl, codes);
    pins(1, 0);
    chk("clear", 0, codes);
    pins(1, 1);
    pins(0, 1);
    chk("restore", mdl, codes);
    @(posedge ref_clk);
    #1 strap = 1;
    word(12'hABC, 1'b1, 3'h7, 16);
    // Four extra rises of the long frame already sent the top nibble
    chk("chain", 16'hF030, rx);
    chk("strap", mdl, codes);
    end_of_test;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    end_of_test;
  end
endmodule
